// ---- src/csu_conditional_skip.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csu_defines.svh"

module csu_conditional_skip
    import csu_pkg::*;
#(
    parameter int PC_W = `CSU_PC_W
)
(
    input wire logic clk_i,                          // 10 MHz core clock
    input wire logic nrst_i,                         // async reset, active low
    input wire logic en_i,                           // clock enable
    input wire logic start_i,                        // decoded skip instruction
    input wire csu_instr_t instr_i,                  // instruction fields
    input wire logic [PC_W-1:0] pc_i,                // address of the opcode
    input wire csu_flags_t flags_i,                  // alu flags
    input wire csu_accs_t accs_i,                    // accumulators
    input wire logic [`CSU_LEN_W-1:0] next_len_i,    // length of instr at pc_o
    output logic busy_o,                             // skipping in progress
    output logic done_o,                             // instruction finished
    output logic taken_o,                            // condition held
    output logic [PC_W-1:0] pc_o                     // running program counter
);

    // ----------------------------------------
    // condition select
    // ----------------------------------------
    function automatic logic csu_pick_bit(input csu_accs_t a, input csu_acc_sel_t s,
                                          input logic [`CSU_BIT_W-1:0] b);
        logic [`CSU_ACC_W-1:0] w;
        w = '0;
        unique case (s)
            CSU_ACC_X: w = a.x;
            CSU_ACC_Y: w = a.y;
            CSU_ACC_Z: w = a.z;
            CSU_ACC_R: w = a.r;
        endcase
        if (b < `CSU_BIT_W'(`CSU_ACC_W))
            csu_pick_bit = w[b];
        else
            csu_pick_bit = 1'b0;
    endfunction

    csu_state_t state_q;
    csu_state_t state_d;
    logic [`CSU_CNT_W-1:0] remain_q;
    logic [`CSU_CNT_W-1:0] remain_d;
    logic [PC_W-1:0] pc_d;
    logic busy_d;
    logic done_d;
    logic taken_d;

    wire logic start_ok;
    wire logic sel_bit;
    logic cond;
    wire logic will_skip;

    assign start_ok = en_i && start_i && (state_q == CSU_ST_IDLE);
    assign sel_bit = csu_pick_bit(accs_i, instr_i.accumulator_select, instr_i.bit_index);

    always_comb
    begin
        cond = 1'b0;
        unique case (instr_i.kind)
            CSU_SKIP_IF_BIT_LOW: cond = !sel_bit;
            CSU_SKIP_IF_BIT_HIGH: cond = sel_bit;
            CSU_SKIP_IF_NO_CARRY: cond = !flags_i.carry;
            CSU_SKIP_IF_CARRY: cond = flags_i.carry;
            CSU_SKIP_IF_RESULT_ZERO: cond = !flags_i.not_zero;
            CSU_SKIP_IF_RESULT_NONZERO: cond = flags_i.not_zero;
            CSU_SKIP_IF_RESULT_NEGATIVE: cond = flags_i.sign;
            CSU_SKIP_IF_RESULT_NONNEGATIVE: cond = !flags_i.sign;
            CSU_SKIP_IF_NO_OVERFLOW: cond = !flags_i.overflow;
            CSU_SKIP_IF_OVERFLOWED: cond = flags_i.overflow;
            default: cond = 1'b0;
        endcase
    end

    // zero count skips nothing; treat it as fall-through
    assign will_skip = cond && (instr_i.skip_count != `CSU_CNT_ZERO);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        remain_d = remain_q;
        pc_d = pc_o;
        busy_d = busy_o;
        done_d = 1'b0;
        taken_d = taken_o;
        unique case (state_q)
            CSU_ST_IDLE:
            begin
                busy_d = 1'b0;
                if (start_i)
                begin
                    pc_d = pc_i + PC_W'(`CSU_OPC_LEN);
                    taken_d = cond;
                    if (will_skip)
                    begin
                        state_d = CSU_ST_SKIP;
                        remain_d = instr_i.skip_count;
                        busy_d = 1'b1;
                    end
                    else
                    begin
                        done_d = 1'b1;
                    end
                end
            end
            CSU_ST_SKIP:
            begin
                pc_d = pc_o + PC_W'(next_len_i);
                remain_d = remain_q - `CSU_CNT_ONE;
                if (remain_q == `CSU_CNT_ONE)
                begin
                    state_d = CSU_ST_IDLE;
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= CSU_ST_IDLE;
            remain_q <= `CSU_CNT_ZERO;
            pc_o <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            taken_o <= 1'b0;
        end
        else if (en_i)
        begin
            state_q <= state_d;
            remain_q <= remain_d;
            pc_o <= pc_d;
            busy_o <= busy_d;
            done_o <= done_d;
            taken_o <= taken_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_bit_low;
        start_ok && instr_i.kind == CSU_SKIP_IF_BIT_LOW |=> taken_o == !$past(sel_bit);
    endproperty
    a_bit_low: assert property (p_bit_low) else $error("bit low test wrong");

    property p_bit_high;
        start_ok && instr_i.kind == CSU_SKIP_IF_BIT_HIGH |=> taken_o == $past(sel_bit);
    endproperty
    a_bit_high: assert property (p_bit_high) else $error("bit high test wrong");

    property p_acc_sel;
        start_ok && instr_i.accumulator_select == CSU_ACC_Z && instr_i.bit_index == 5'h17
            |-> sel_bit == accs_i.z[23];
    endproperty
    a_acc_sel: assert property (p_acc_sel) else $error("accumulator bit pick wrong");

    property p_skip_len;
        en_i && state_q == CSU_ST_SKIP |=> pc_o == $past(pc_o) + PC_W'($past(next_len_i));
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip length not added");

    property p_carry;
        start_ok && instr_i.kind inside {CSU_SKIP_IF_NO_CARRY, CSU_SKIP_IF_CARRY}
            |=> taken_o == ($past(flags_i.carry) ^ ($past(instr_i.kind) == CSU_SKIP_IF_NO_CARRY));
    endproperty
    a_carry: assert property (p_carry) else $error("carry test wrong");

    property p_zero;
        start_ok && instr_i.kind inside {CSU_SKIP_IF_RESULT_ZERO, CSU_SKIP_IF_RESULT_NONZERO}
            |=> taken_o == ($past(flags_i.not_zero)
                ^ ($past(instr_i.kind) == CSU_SKIP_IF_RESULT_ZERO));
    endproperty
    a_zero: assert property (p_zero) else $error("zero test wrong");

    property p_sign;
        start_ok && instr_i.kind inside {CSU_SKIP_IF_RESULT_NEGATIVE,
            CSU_SKIP_IF_RESULT_NONNEGATIVE}
            |=> taken_o == ($past(flags_i.sign)
                ^ ($past(instr_i.kind) == CSU_SKIP_IF_RESULT_NONNEGATIVE));
    endproperty
    a_sign: assert property (p_sign) else $error("sign test wrong");

    property p_ovf;
        start_ok && instr_i.kind inside {CSU_SKIP_IF_NO_OVERFLOW, CSU_SKIP_IF_OVERFLOWED}
            |=> taken_o == ($past(flags_i.overflow)
                ^ ($past(instr_i.kind) == CSU_SKIP_IF_NO_OVERFLOW));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow test wrong");

    property p_cycles;
        start_ok && will_skip && instr_i.skip_count == 2'h2 ##1 en_i [*2]
            |=> done_o && !busy_o;
    endproperty
    a_cycles: assert property (p_cycles) else $error("two-skip timing wrong");

    property p_fall;
        start_ok && !will_skip
            |=> done_o && !busy_o && pc_o == $past(pc_i) + PC_W'(`CSU_OPC_LEN);
    endproperty
    a_fall: assert property (p_fall) else $error("fall-through wrong");

endmodule
`default_nettype wire

// ---- src/csu_defines.svh ----
`ifndef CSU_DEFINES_SVH
`define CSU_DEFINES_SVH

// ----------------------------------------
// widths and constants
// ----------------------------------------
`define CSU_ACC_W 24
`define CSU_BIT_W 5
`define CSU_LEN_W 3
`define CSU_CNT_W 2
`define CSU_PC_W 16
`define CSU_OPC_LEN 3'h1
`define CSU_CNT_ZERO 2'h0
`define CSU_CNT_ONE 2'h1

`endif

// ---- src/csu_pkg.sv ----
`include "csu_defines.svh"

package csu_pkg;

    // ----------------------------------------
    // instruction kinds
    // ----------------------------------------
    typedef enum logic [3:0] {
        CSU_SKIP_IF_BIT_LOW = 4'h0,
        CSU_SKIP_IF_BIT_HIGH = 4'h1,
        CSU_SKIP_IF_NO_CARRY = 4'h2,
        CSU_SKIP_IF_CARRY = 4'h3,
        CSU_SKIP_IF_RESULT_ZERO = 4'h4,
        CSU_SKIP_IF_RESULT_NONZERO = 4'h5,
        CSU_SKIP_IF_RESULT_NEGATIVE = 4'h6,
        CSU_SKIP_IF_RESULT_NONNEGATIVE = 4'h7,
        CSU_SKIP_IF_NO_OVERFLOW = 4'h8,
        CSU_SKIP_IF_OVERFLOWED = 4'h9
    } csu_kind_t;

    typedef enum logic [1:0] {
        CSU_ACC_X = 2'h0,
        CSU_ACC_Y = 2'h1,
        CSU_ACC_Z = 2'h2,
        CSU_ACC_R = 2'h3
    } csu_acc_sel_t;

    typedef enum logic {
        CSU_ST_IDLE = 1'b0,
        CSU_ST_SKIP = 1'b1
    } csu_state_t;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic carry;
        logic overflow;
        logic sign;
        logic not_zero;
    } csu_flags_t;

    typedef struct packed {
        logic [`CSU_ACC_W-1:0] x;
        logic [`CSU_ACC_W-1:0] y;
        logic [`CSU_ACC_W-1:0] z;
        logic [`CSU_ACC_W-1:0] r;
    } csu_accs_t;

    typedef struct packed {
        csu_kind_t kind;
        csu_acc_sel_t accumulator_select;
        logic [`CSU_BIT_W-1:0] bit_index;
        logic [`CSU_CNT_W-1:0] skip_count;
    } csu_instr_t;

endpackage

// ---- verif/csu_conditional_skip_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module csu_conditional_skip_tb import csu_pkg::*;;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic en_i = 1'b1;
    logic start_i = 1'b0;
    csu_instr_t instr_i = '0;
    logic [15:0] pc_i = '0;
    csu_flags_t flags_i = '0;
    csu_accs_t accs_i = '0;
    logic [2:0] next_len_i = '0;
    logic busy_o;
    logic done_o;
    logic taken_o;
    logic [15:0] pc_o;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [23:0] acc_v [4] = '{24'ha5a5a5, 24'h5a5a5a, 24'h800001, 24'h7ffffe};

    csu_conditional_skip i_dut (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(en_i),
        .start_i(start_i),
        .instr_i(instr_i),
        .pc_i(pc_i),
        .flags_i(flags_i),
        .accs_i(accs_i),
        .next_len_i(next_len_i),
        .busy_o(busy_o),
        .done_o(done_o),
        .taken_o(taken_o),
        .pc_o(pc_o)
    );

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    function automatic logic cond(input csu_kind_t k, input csu_flags_t f, input logic bv);
        case (k)
            CSU_SKIP_IF_BIT_LOW: return !bv;
            CSU_SKIP_IF_BIT_HIGH: return bv;
            CSU_SKIP_IF_NO_CARRY: return !f.carry;
            CSU_SKIP_IF_CARRY: return f.carry;
            CSU_SKIP_IF_RESULT_ZERO: return !f.not_zero;
            CSU_SKIP_IF_RESULT_NONZERO: return f.not_zero;
            CSU_SKIP_IF_RESULT_NEGATIVE: return f.sign;
            CSU_SKIP_IF_RESULT_NONNEGATIVE: return !f.sign;
            CSU_SKIP_IF_NO_OVERFLOW: return !f.overflow;
            CSU_SKIP_IF_OVERFLOWED: return f.overflow;
            default: return 1'b0;
        endcase
    endfunction

    // one instruction; poke = start while busy, stall = enable low mid-skip
    task automatic run(input csu_kind_t k, input csu_acc_sel_t s, input logic [4:0] b,
            input logic [1:0] n, input csu_flags_t f, input bit poke, input bit stall);
        logic [15:0] pc;
        logic tk;
        int steps;
        pc = 16'h1000 + 16'(b);
        tk = cond(k, f, (b < 5'h18) ? acc_v[s][b] : 1'b0);
        steps = tk ? int'(n) : 0;
        @(posedge clk_i);
        start_i <= 1'b1;
        instr_i <= '{k, s, b, n};
        pc_i <= pc;
        flags_i <= f;
        @(posedge clk_i);
        start_i <= 1'b0;
        en_i <= !stall;
        next_len_i <= 3'h3;
        #1;
        pc = pc + 16'h1;
        check("taken_o", 16'(tk), 16'(taken_o));
        check("done_o", 16'(steps == 0), 16'(done_o));
        check("busy_o", 16'(steps != 0), 16'(busy_o));
        check("pc_o", pc, pc_o);
        if (stall)
        begin
            repeat (2) @(posedge clk_i);
            #1;
            check("pc_o", pc, pc_o);
            check("busy_o", 16'h1, 16'(busy_o));
            check("done_o", 16'h0, 16'(done_o));
            @(posedge clk_i);
            en_i <= 1'b1;
        end
        for (int i = 0; i < steps; i++)
        begin
            @(posedge clk_i);
            start_i <= poke && i == 0;
            pc_i <= ~pc;
            next_len_i <= 3'(i + 4);
            #1;
            pc = pc + 16'(i + 3);
            check("pc_o", pc, pc_o);
            check("done_o", 16'(i == steps - 1), 16'(done_o));
            check("busy_o", 16'(i != steps - 1), 16'(busy_o));
        end
        @(posedge clk_i);
        #1;
        check("done_o", 16'h0, 16'(done_o));
        check("pc_o", pc, pc_o);
        check("taken_o", 16'(tk), 16'(taken_o));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        #1;
        check("pc_o", 16'h0, pc_o);
        check("busy_o", 16'h0, 16'(busy_o));
        check("taken_o", 16'h0, 16'(taken_o));
    endtask

    task automatic t_bits();
        for (int s = 0; s < 4; s++)
            for (int b = 0; b < 24; b++)
            begin
                run(CSU_SKIP_IF_BIT_LOW, csu_acc_sel_t'(s), 5'(b), 2'(b % 3 + 1), '0, 0, 0);
                run(CSU_SKIP_IF_BIT_HIGH, csu_acc_sel_t'(s), 5'(b), 2'(b % 3 + 1), '0, 0, 0);
            end
    endtask

    task automatic t_flags();
        for (int k = 2; k < 10; k++)
            for (int f = 0; f < 16; f++)
                run(csu_kind_t'(k), CSU_ACC_X, 5'h0, 2'(f % 3 + 1), 4'(f), 0, 0);
    endtask

    // out-of-range bit, zero count, unused kind code
    task automatic t_edges();
        run(CSU_SKIP_IF_BIT_LOW, CSU_ACC_R, 5'h18, 2'h1, 4'h0, 1'b0, 1'b0);
        run(CSU_SKIP_IF_BIT_HIGH, CSU_ACC_R, 5'h1f, 2'h3, 4'h0, 1'b0, 1'b0);
        run(CSU_SKIP_IF_CARRY, CSU_ACC_X, 5'h0, 2'h0, 4'h8, 1'b0, 1'b0);
        run(csu_kind_t'(4'hc), CSU_ACC_X, 5'h0, 2'h2, 4'hf, 1'b0, 1'b0);
    endtask

    // reset in the middle of a skip
    task automatic t_mid_reset();
        @(posedge clk_i);
        start_i <= 1'b1;
        instr_i <= '{CSU_SKIP_IF_CARRY, CSU_ACC_X, 5'h0, 2'h3};
        pc_i <= 16'h2000;
        flags_i <= 4'h8;
        @(posedge clk_i);
        start_i <= 1'b0;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        #1;
        check("busy_o", 16'h0, 16'(busy_o));
        check("pc_o", 16'h0, pc_o);
        check("taken_o", 16'h0, 16'(taken_o));
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        check("done_o", 16'h0, 16'(done_o));
        check("busy_o", 16'h0, 16'(busy_o));
        check("pc_o", 16'h0, pc_o);
    endtask

    task automatic t_busy();
        run(CSU_SKIP_IF_CARRY, CSU_ACC_X, 5'h0, 2'h3, 4'h8, 1, 0);
    endtask

    task automatic t_stall();
        run(CSU_SKIP_IF_RESULT_ZERO, CSU_ACC_Y, 5'h0, 2'h2, 4'h0, 0, 1);
    endtask

    initial
    begin
        repeat (3) @(posedge clk_i);
        accs_i <= {acc_v[0], acc_v[1], acc_v[2], acc_v[3]};
        t_reset();
        @(posedge clk_i);
        nrst_i <= 1'b1;
        t_bits();
        t_flags();
        t_edges();
        t_mid_reset();
        t_busy();
        t_stall();
        tally_and_finish();
    end

endmodule

`default_nettype wire
